// ### src/btc_pkg.sv
package btc_pkg;
  // host i/o map of the timing block
  localparam logic [7:0] ADDR_T0_DATA_LO = 8'h80;
  localparam logic [7:0] ADDR_T0_DATA_HI = 8'h81;
  localparam logic [7:0] ADDR_T0_RLD_LO  = 8'h82;
  localparam logic [7:0] ADDR_T0_RLD_HI  = 8'h83;
  localparam logic [7:0] ADDR_T1_DATA_LO = 8'h84;
  localparam logic [7:0] ADDR_T1_DATA_HI = 8'h85;
  localparam logic [7:0] ADDR_T1_RLD_LO  = 8'h86;
  localparam logic [7:0] ADDR_T1_RLD_HI  = 8'h87;
  localparam logic [7:0] ADDR_CHAN0      = 8'h88;
  localparam logic [7:0] ADDR_PERIPH_CMD = 8'h8e;
  localparam logic [7:0] ADDR_TMR_CTRL   = 8'h90;
  localparam logic [7:0] ADDR_TIMER_OUTPUT_LINE_MODE  = 8'h91;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;
  localparam int         NUM_CHAN        = 4;
  // timer control register fields
  localparam int TCR_EN  = 0;
  localparam int TCR_IE  = 2;
  localparam int TCR_RLD = 4;
  localparam int TCR_FLG = 6;
  // timing
  localparam int          PRT_DIV      = 20;
  localparam logic [4:0]  PRT_DIV_LAST = 5'(PRT_DIV - 1);
  localparam logic [3:0]  PRE16_LAST   = 4'hf;
  localparam logic [7:0]  PRE256_LAST  = 8'hff;
  localparam logic [1:0]  QUARTER_LAST = 2'h3;
  // channel control word fields
  localparam int CW_CTL  = 0;
  localparam int CW_RST  = 1;
  localparam int CW_TCF  = 2;
  localparam int CW_TRIG = 3;
  localparam int CW_RISE = 4;
  localparam int CW_P256 = 5;
  localparam int CW_CNTR = 6;
  localparam int CW_IE   = 7;
  localparam logic [7:0] CW_RESET = 8'h03;
  // peripheral command register fields
  localparam int CMD_PRIO    = 0;
  localparam int CMD_RST_PAR = 2;
  localparam int CMD_RST_SER = 3;
  localparam int CMD_RST_CTR = 4;
  localparam int CMD_AUX     = 5;
  localparam int CMD_BAUD_A  = 6;
  localparam int CMD_BAUD_B  = 7;
  localparam logic [7:0] CMD_RESET = 8'h00;
  typedef enum logic [1:0] {
    BTC_TIMER_OUTPUT_LINE_LOW    = 2'h0,
    BTC_TIMER_OUTPUT_LINE_HIGH   = 2'h1,
    BTC_TIMER_OUTPUT_LINE_TOGGLE = 2'h2
  } btc_timer_output_line_mode_t;
  typedef enum logic [2:0] {
    BTC_CH_IDLE = 3'b001,
    BTC_CH_WAIT = 3'b010,
    BTC_CH_RUN  = 3'b100
  } btc_ch_state_t;
endpackage

// ### src/btc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface btc_prt_if;
  logic        load_lo;
  logic        load_hi;
  logic [7:0]  wdata;
  logic        tick;
  logic        en;
  logic        rld;
  logic [15:0] reload;
  logic [15:0] cnt;
  logic        hit;
  modport ctl (output load_lo, load_hi, wdata, tick, en, rld, reload, input cnt, hit);
  modport tmr (input load_lo, load_hi, wdata, tick, en, rld, reload, output cnt, hit);
endinterface // btc_prt_if

interface btc_ctc_if;
  logic       wr;
  logic [7:0] wdata;
  logic       p16;
  logic       p256;
  logic       rise;
  logic       fall;
  logic       urst;
  logic [7:0] cnt;
  logic       zc;
  logic       hit;
  logic       ie;
  modport ctl (output wr, wdata, p16, p256, rise, fall, urst, input cnt, zc, hit, ie);
  modport ch  (input wr, wdata, p16, p256, rise, fall, urst, output cnt, zc, hit, ie);
endinterface // btc_ctc_if
`default_nettype wire

// ### src/btc_prt.sv
`timescale 1ns/1ps
`default_nettype none
module btc_prt
  import btc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  btc_prt_if.tmr    bus
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        hit;
  } btc_prt_st_t;
  btc_prt_st_t st_reg, st_next;
  logic [15:0] dec;

  always_comb
  begin
    st_next = st_reg;
    st_next.hit = 1'b0;
    dec = st_reg.cnt - 16'h0001;
    // a stopped timer sits at zero and does not wrap
    if (bus.tick && bus.en && st_reg.cnt != 16'h0000)
    begin
      st_next.cnt = dec;
      if (dec == 16'h0000)
      begin
        st_next.hit = 1'b1;
        if (bus.rld)
        begin
          st_next.cnt = bus.reload;
        end
      end
    end
    // host may rewrite the count at any time, even mid-interval
    if (bus.load_lo)
    begin
      st_next.cnt[7:0] = bus.wdata;
    end
    if (bus.load_hi)
    begin
      st_next.cnt[15:8] = bus.wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus.cnt = st_reg.cnt;
  assign bus.hit = st_reg.hit;
endmodule // btc_prt
`default_nettype wire

// ### src/btc_ctc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module btc_ctc_chan
  import btc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  btc_ctc_if.ch     bus
);
  typedef struct packed {
    btc_ch_state_t state;
    logic [7:0]    ctl;
    logic [7:0]    tconst;
    logic [7:0]    cnt;
    logic          tc_pend;
    logic          zc;
    logic          hit;
  } btc_ch_st_t;
  btc_ch_st_t st_reg, st_next;
  logic edge_sel;
  logic tick;

  always_comb
  begin
    st_next = st_reg;
    st_next.hit = 1'b0;
    edge_sel = st_reg.ctl[CW_RISE] ? bus.rise : bus.fall;
    // pin edges (quarter-rate clock on a selected baud channel) clock in counter mode, prescaled system clock in timer mode
    if (st_reg.ctl[CW_CNTR])
    begin
      tick = edge_sel;
    end
    else
    begin
      tick = st_reg.ctl[CW_P256] ? bus.p256 : bus.p16;
    end
    if (st_reg.ctl[CW_CNTR] == 1'b0)
    begin
      st_next.zc = 1'b0;
    end
    case (st_reg.state)
      BTC_CH_WAIT:
      begin
        if (edge_sel)
        begin
          st_next.state = BTC_CH_RUN;
        end
      end
      BTC_CH_RUN:
      begin
        if (tick)
        begin
          st_next.cnt = st_reg.cnt - 8'h01;
          if (st_reg.cnt == 8'h01)
          begin
            st_next.hit = 1'b1;
            st_next.zc  = 1'b1;
            if (st_reg.ctl[CW_CNTR])
            begin
              st_next.state = BTC_CH_IDLE;
              st_next.cnt   = 8'h00;
            end
            else
            begin
              st_next.cnt = st_reg.tconst;
            end
          end
        end
      end
      default:
      begin
        st_next.state = BTC_CH_IDLE;
      end
    endcase
    if (bus.wr)
    begin
      if (st_reg.tc_pend)
      begin
        st_next.tconst  = bus.wdata;
        st_next.cnt     = bus.wdata;
        st_next.tc_pend = 1'b0;
        st_next.zc      = 1'b0;
        if (st_reg.ctl[CW_TRIG] && !st_reg.ctl[CW_CNTR])
        begin
          st_next.state = BTC_CH_WAIT;
        end
        else
        begin
          st_next.state = BTC_CH_RUN;
        end
      end
      else if (bus.wdata[CW_CTL])
      begin
        st_next.ctl     = bus.wdata;
        st_next.tc_pend = bus.wdata[CW_TCF];
        if (bus.wdata[CW_RST])
        begin
          st_next.state = BTC_CH_IDLE;
          st_next.zc    = 1'b0;
        end
      end
    end
    if (bus.urst)
    begin
      st_next = '{state: BTC_CH_IDLE, ctl: CW_RESET, default: '0};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_reg <= '{state: BTC_CH_IDLE, ctl: CW_RESET, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus.cnt = st_reg.cnt;
  assign bus.zc  = st_reg.zc;
  assign bus.hit = st_reg.hit;
  assign bus.ie  = st_reg.ctl[CW_IE];
endmodule // btc_ctc_chan
`default_nettype wire

// ### src/btc_timers.sv
`timescale 1ns/1ps
`default_nettype none
module btc_timers
  import btc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_io_addr,
  input  wire logic [7:0] i_io_wdata,
  input  wire logic       i_io_wr,
  input  wire logic       i_io_rd,
  input  wire logic       i_int_ack,
  input  wire logic [3:0] i_clock_or_trigger_input,
  output logic      [7:0] o_io_rdata,
  output logic      [1:0] o_cpu_irq,
  output logic            o_periph_irq,
  output logic      [7:0] o_int_vector,
  output logic            o_timer_output_line,
  output logic      [3:0] o_zero_count_output,
  output logic            o_baud_clk_a,
  output logic            o_baud_clk_b,
  output logic            o_reset_parallel,
  output logic            o_reset_serial,
  output logic            o_auxiliary_port_ctl,
  output logic      [1:0] o_prio_order
);
  typedef struct packed {
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic [3:0]  sy3;
    logic [4:0]  div20;
    logic [7:0]  pre;
    logic [1:0]  qdiv;
    logic [1:0]  en;
    logic [1:0]  ie;
    logic [1:0]  rld;
    logic [1:0]  flag;
    logic [1:0]  omode;
    logic        timer_output_line;
    logic [15:0] rl0;
    logic [15:0] rl1;
    logic [7:0]  cmd;
    logic        rst_par;
    logic        rst_ser;
    logic        rst_ctr;
    logic [4:0]  vbase;
    logic        tcp0;
    logic [3:0]  pend;
    logic [1:0]  cpu_irq;
    logic        per_irq;
    logic [7:0]  vec;
    logic [1:0]  vsel;
    logic [7:0]  rdata;
  } btc_top_st_t;

  btc_top_st_t st_reg, st_next;

  btc_prt_if prt_bus [2] ();
  btc_ctc_if ch_bus [NUM_CHAN] ();

  logic [15:0] prt_cnt [2];
  logic [1:0]  prt_hit;
  logic [7:0]  ch_cnt [NUM_CHAN];
  logic [3:0]  ch_zc;
  logic [3:0]  ch_hit;
  logic [3:0]  ch_ie;
  logic        tick20;
  logic        p16;
  logic        p256;
  logic        quarter;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [3:0]  ch_wr;

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] r;
    r = 2'd0;
    if (v[3]) r = 2'd3;
    if (v[2]) r = 2'd2;
    if (v[1]) r = 2'd1;
    if (v[0]) r = 2'd0;
    first_set = r;
  endfunction

  // enable pulses taken from registered dividers, one system clock wide
  assign tick20  = (st_reg.div20 == PRT_DIV_LAST);
  assign p16     = (st_reg.pre[3:0] == PRE16_LAST);
  assign p256    = (st_reg.pre == PRE256_LAST);
  assign quarter = (st_reg.qdiv == QUARTER_LAST);
  assign rise    = st_reg.sy2 & ~st_reg.sy3;
  assign fall    = ~st_reg.sy2 & st_reg.sy3;

  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      ch_wr[i] = i_io_wr && (i_io_addr == ADDR_CHAN0 + 8'(i));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_prt
      assign prt_bus[g].load_lo = i_io_wr && (i_io_addr == (g == 0 ? ADDR_T0_DATA_LO
                                                                   : ADDR_T1_DATA_LO));
      assign prt_bus[g].load_hi = i_io_wr && (i_io_addr == (g == 0 ? ADDR_T0_DATA_HI
                                                                   : ADDR_T1_DATA_HI));
      assign prt_bus[g].wdata   = i_io_wdata;
      assign prt_bus[g].tick    = tick20;
      assign prt_bus[g].en      = st_reg.en[g];
      assign prt_bus[g].rld     = st_reg.rld[g];
      assign prt_bus[g].reload  = (g == 0) ? st_reg.rl0 : st_reg.rl1;
      assign prt_cnt[g]         = prt_bus[g].cnt;
      assign prt_hit[g]         = prt_bus[g].hit;
      btc_prt u_prt (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .bus     (prt_bus[g])
      );
    end
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_ch
      // the two baud channels may take the quarter-rate clock instead of the pin
      if (g >= 2)
      begin : g_baud
        logic qsel;
        assign qsel = st_reg.cmd[CMD_BAUD_A + g - 2];
        assign ch_bus[g].rise = qsel ? quarter : rise[g];
        assign ch_bus[g].fall = qsel ? quarter : fall[g];
      end
      else
      begin : g_pin
        assign ch_bus[g].rise = rise[g];
        assign ch_bus[g].fall = fall[g];
      end
      // vector words go to channel zero only, never into a channel's control
      assign ch_bus[g].wr    = ch_wr[g];
      assign ch_bus[g].wdata = i_io_wdata;
      assign ch_bus[g].p16   = p16;
      assign ch_bus[g].p256  = p256;
      assign ch_bus[g].urst  = st_reg.rst_ctr;
      assign ch_cnt[g]       = ch_bus[g].cnt;
      assign ch_zc[g]        = ch_bus[g].zc;
      assign ch_hit[g]       = ch_bus[g].hit;
      assign ch_ie[g]        = ch_bus[g].ie;
      btc_ctc_chan u_ch (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .bus     (ch_bus[g])
      );
    end
  endgenerate

  always_comb
  begin
    st_next = st_reg;
    st_next.sy1 = i_clock_or_trigger_input;
    st_next.sy2 = st_reg.sy1;
    st_next.sy3 = st_reg.sy2;
    st_next.div20 = tick20 ? 5'h00 : st_reg.div20 + 5'h01;
    st_next.pre   = st_reg.pre + 8'h01;
    st_next.qdiv  = st_reg.qdiv + 2'h1;
    st_next.rst_par = 1'b0;
    st_next.rst_ser = 1'b0;
    st_next.rst_ctr = 1'b0;

    // register writes
    if (i_io_wr)
    begin
      if (i_io_addr == ADDR_T0_RLD_LO)
      begin
        st_next.rl0[7:0] = i_io_wdata;
      end
      else if (i_io_addr == ADDR_T0_RLD_HI)
      begin
        st_next.rl0[15:8] = i_io_wdata;
      end
      else if (i_io_addr == ADDR_T1_RLD_LO)
      begin
        st_next.rl1[7:0] = i_io_wdata;
      end
      else if (i_io_addr == ADDR_T1_RLD_HI)
      begin
        st_next.rl1[15:8] = i_io_wdata;
      end
      else if (i_io_addr == ADDR_TMR_CTRL)
      begin
        st_next.en  = i_io_wdata[TCR_EN +: 2];
        st_next.ie  = i_io_wdata[TCR_IE +: 2];
        st_next.rld = i_io_wdata[TCR_RLD +: 2];
      end
      else if (i_io_addr == ADDR_TIMER_OUTPUT_LINE_MODE)
      begin
        st_next.omode = i_io_wdata[1:0];
      end
      else if (i_io_addr == ADDR_PERIPH_CMD)
      begin
        st_next.cmd     = i_io_wdata;
        st_next.rst_par = i_io_wdata[CMD_RST_PAR];
        st_next.rst_ser = i_io_wdata[CMD_RST_SER];
        st_next.rst_ctr = i_io_wdata[CMD_RST_CTR];
        st_next.cmd[CMD_RST_PAR] = 1'b0;
        st_next.cmd[CMD_RST_SER] = 1'b0;
        st_next.cmd[CMD_RST_CTR] = 1'b0;
      end
      else if (ch_wr[0])
      begin
        // mirror of channel zero's pending constant: an even constant is no vector
        st_next.tcp0 = !st_reg.tcp0 && i_io_wdata[CW_CTL] && i_io_wdata[CW_TCF];
        if (!st_reg.tcp0 && !i_io_wdata[CW_CTL])
        begin
          st_next.vbase = i_io_wdata[7:3];
        end
      end
    end

    // register reads; counts are sampled, never disturbed
    if (i_io_rd)
    begin
      if (i_io_addr == ADDR_T0_DATA_LO || i_io_addr == ADDR_T0_DATA_HI)
      begin
        st_next.rdata = pick_byte(prt_cnt[0], i_io_addr[0]);
      end
      else if (i_io_addr == ADDR_T1_DATA_LO || i_io_addr == ADDR_T1_DATA_HI)
      begin
        st_next.rdata = pick_byte(prt_cnt[1], i_io_addr[0]);
      end
      else if (i_io_addr == ADDR_T0_RLD_LO || i_io_addr == ADDR_T0_RLD_HI)
      begin
        st_next.rdata = pick_byte(st_reg.rl0, i_io_addr[0]);
      end
      else if (i_io_addr == ADDR_T1_RLD_LO || i_io_addr == ADDR_T1_RLD_HI)
      begin
        st_next.rdata = pick_byte(st_reg.rl1, i_io_addr[0]);
      end
      else if (i_io_addr >= ADDR_CHAN0 && i_io_addr < ADDR_CHAN0 + 8'(NUM_CHAN))
      begin
        st_next.rdata = ch_cnt[i_io_addr[1:0]];
      end
      else if (i_io_addr == ADDR_TMR_CTRL)
      begin
        st_next.rdata = {st_reg.flag, st_reg.rld, st_reg.ie, st_reg.en};
        st_next.flag  = 2'b00;
      end
      else if (i_io_addr == ADDR_TIMER_OUTPUT_LINE_MODE)
      begin
        st_next.rdata = {6'h00, st_reg.omode};
      end
      else
      begin
        st_next.rdata = RD_UNMAPPED;
      end
    end

    // termination flags: a new termination beats the read-clear
    st_next.flag    = st_next.flag | prt_hit;
    st_next.cpu_irq = st_next.flag & st_reg.ie;

    // timer output line
    case (st_reg.omode)
      BTC_TIMER_OUTPUT_LINE_LOW:
      begin
        st_next.timer_output_line = 1'b0;
      end
      BTC_TIMER_OUTPUT_LINE_HIGH:
      begin
        st_next.timer_output_line = 1'b1;
      end
      BTC_TIMER_OUTPUT_LINE_TOGGLE:
      begin
        // one flip per reload gives equal high and low halves
        if (prt_hit[1] && st_reg.rld[1])
        begin
          st_next.timer_output_line = ~st_reg.timer_output_line;
        end
      end
      default:
      begin
        st_next.timer_output_line = st_reg.timer_output_line;
      end
    endcase

    // channel interrupts: acknowledge clears the presented source
    if (i_int_ack && st_reg.per_irq)
    begin
      st_next.pend[st_reg.vsel] = 1'b0;
    end
    st_next.pend    = st_next.pend | (ch_hit & ch_ie);
    st_next.per_irq = |st_next.pend;
    st_next.vsel    = first_set(st_next.pend);
    st_next.vec     = {st_reg.vbase, st_next.vsel, 1'b0};
    if (st_reg.rst_ctr)
    begin
      st_next.pend    = 4'h0;
      st_next.per_irq = 1'b0;
      st_next.tcp0    = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_reg <= '{cmd: CMD_RESET, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_io_rdata           = st_reg.rdata;
  assign o_cpu_irq            = st_reg.cpu_irq;
  assign o_periph_irq         = st_reg.per_irq;
  assign o_int_vector         = st_reg.vec;
  assign o_timer_output_line  = st_reg.timer_output_line;
  assign o_zero_count_output  = ch_zc;
  assign o_baud_clk_a         = ch_zc[2];
  assign o_baud_clk_b         = ch_zc[3];
  assign o_reset_parallel     = st_reg.rst_par;
  assign o_reset_serial       = st_reg.rst_ser;
  assign o_auxiliary_port_ctl = st_reg.cmd[CMD_AUX];
  assign o_prio_order         = st_reg.cmd[CMD_PRIO +: 2];
endmodule // btc_timers
`default_nettype wire

// ### sim/btc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module btc_host_model
  import btc_pkg::*;
(
  input  wire logic       i_clk,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial
  begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // idle cycle after each access so a strobe never re-asserts in one step
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= w;
    o_rd    <= !w;
    @(negedge i_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_wdata <= ~d;
  endtask
  function automatic logic [15:0] legal_count(input logic [15:0] v);
    return (v < 16'h0002) ? 16'h0002 : v;
  endfunction
endmodule // btc_host_model
`default_nettype wire

// ### sim/btc_timers_properties.sv
`timescale 1ns/1ps
`default_nettype none
module btc_timers_properties
  import btc_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic       i_io_wr,
  input wire logic       i_io_rd,
  input wire logic [7:0] o_io_rdata,
  input wire logic       o_periph_irq,
  input wire logic [7:0] o_int_vector,
  input wire logic       o_timer_output_line,
  input wire logic [3:0] o_zero_count_output,
  input wire logic       o_baud_clk_a,
  input wire logic       o_baud_clk_b,
  input wire logic       o_reset_parallel,
  input wire logic [1:0] o_prio_order
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence cmd_wr_s;
    i_io_wr && i_io_addr == ADDR_PERIPH_CMD;
  endsequence
  sequence mode_wr_s(logic [1:0] m);
    i_io_wr && i_io_addr == ADDR_TIMER_OUTPUT_LINE_MODE && i_io_wdata[1:0] == m;
  endsequence
  unmapped_read_a: assert property (
    i_io_rd && i_io_addr > ADDR_TIMER_OUTPUT_LINE_MODE |=> o_io_rdata == RD_UNMAPPED)
    else $error("unmapped read not zero");
  prio_set_a: assert property (
    cmd_wr_s |=> o_prio_order == $past(i_io_wdata[1:0]))
    else $error("priority order not taken");
  par_pulse_a: assert property (
    cmd_wr_s ##0 i_io_wdata[CMD_RST_PAR] |=> o_reset_parallel ##1 !o_reset_parallel)
    else $error("parallel reset not one pulse");
  timer_output_line_high_a: assert property (
    mode_wr_s(2'h1) |-> ##[1:2] o_timer_output_line)
    else $error("timer line not high");
  timer_output_line_low_a: assert property (
    mode_wr_s(2'h0) |-> ##[1:2] !o_timer_output_line)
    else $error("timer line not low");
  baud_a_a: assert property (
    o_baud_clk_a == o_zero_count_output[2])
    else $error("baud a differs from channel two");
  baud_b_a: assert property (
    o_baud_clk_b == o_zero_count_output[3])
    else $error("baud b differs from channel three");
  vector_even_a: assert property (
    o_periph_irq |-> o_int_vector[0] == 1'b0)
    else $error("vector low bit set");
  rdata_hold_a: assert property (
    !$past(i_io_rd) |-> $stable(o_io_rdata))
    else $error("read data moved without read");
endmodule // btc_timers_properties
bind btc_timers btc_timers_properties u_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata),
  .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
  .o_periph_irq(o_periph_irq), .o_int_vector(o_int_vector),
  .o_timer_output_line(o_timer_output_line), .o_zero_count_output(o_zero_count_output),
  .o_baud_clk_a(o_baud_clk_a), .o_baud_clk_b(o_baud_clk_b),
  .o_reset_parallel(o_reset_parallel), .o_prio_order(o_prio_order)
);
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import btc_pkg::*;
;
  logic        i_clk;
  logic        i_reset;
  logic        i_int_ack;
  logic [3:0]  pins;
  logic        rd_seen;
  logic [15:0] cnt;
  logic [7:0]  exp_q[$];
  int          err_count;
  int          checks_done;
  int          seed;
  int          n;
  int          hi;
  wire  [7:0]  addr, wdata, rdata, vec;
  wire  [1:0]  cirq, prio;
  wire  [3:0]  zc;
  wire         wr, rd, pirq, timer_output_line, bauda, baudb, rser, aux;
  btc_timers u_btc_timers (
    .i_clk(i_clk), .i_reset(i_reset), .i_io_addr(addr), .i_io_wdata(wdata),
    .i_io_wr(wr), .i_io_rd(rd), .i_int_ack(i_int_ack), .i_clock_or_trigger_input(pins),
    .o_io_rdata(rdata), .o_cpu_irq(cirq), .o_periph_irq(pirq), .o_int_vector(vec),
    .o_timer_output_line(timer_output_line), .o_zero_count_output(zc), .o_baud_clk_a(bauda),
    .o_baud_clk_b(baudb), .o_reset_parallel(), .o_reset_serial(rser),
    .o_auxiliary_port_ctl(aux), .o_prio_order(prio)
  );
  btc_host_model u_btc_host_model (
    .i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_btc_host_model.access(1'b1, a, d);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_btc_host_model.access(1'b0, a, 8'h00);
  endtask
  // read data is registered, so it is judged one edge after the strobe
  always @(posedge i_clk)
    rd_seen <= rd;
  always @(negedge i_clk)
    if (rd_seen === 1'b1)
      check("io_rdata", 16'(rdata), 16'(exp_q.pop_front()));
  task automatic wait_zc(input int i, output int k);
    k = 0;
    do
    begin
      @(negedge i_clk);
      k++;
    end
    while (zc[i] !== 1'b1 && k < 600);
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    while (cirq[0] !== 1'b1 && k < 200)
    begin
      @(negedge i_clk);
      k++;
    end
  endtask
  task automatic run_len(input logic lvl, output int k);
    k = 0;
    while (timer_output_line === lvl && k < 600)
    begin
      @(negedge i_clk);
      k++;
    end
  endtask
  // held four cycles so the two-stage synchroniser cannot miss it
  task automatic pulse_pin(input int i);
    pins[i] = 1'b1;
    repeat (4) @(negedge i_clk);
    pins[i] = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    give_verdict;
  end
  initial
  begin
    seed = 32'hd188;
    err_count = 0;
    checks_done = 0;
    rd_seen = 1'b0;
    i_int_ack = 1'b0;
    pins = 4'h0;
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    rd_exp(8'h9f, RD_UNMAPPED);
    cnt = u_btc_host_model.legal_count(16'($random(seed)));
    wr_reg(ADDR_T0_DATA_LO, cnt[7:0]);
    wr_reg(ADDR_T0_DATA_HI, cnt[15:8]);
    rd_exp(ADDR_T0_DATA_LO, cnt[7:0]);
    rd_exp(ADDR_T0_DATA_HI, cnt[15:8]);
    $display("test registers done");
    wr_reg(ADDR_T0_DATA_LO, 8'h02);
    wr_reg(ADDR_T0_DATA_HI, 8'h00);
    wr_reg(ADDR_T0_RLD_LO, 8'h02);
    wr_reg(ADDR_T0_RLD_HI, 8'h00);
    wr_reg(ADDR_TMR_CTRL, 8'h15);
    wait_irq(n);
    check("t0_interval", 16'(n >= 20 && n <= 60), 16'h0001);
    rd_exp(ADDR_TMR_CTRL, 8'h55);
    repeat (2) @(negedge i_clk);
    check("t0_irq_clear", 16'(cirq[0]), 16'h0000);
    wait_irq(n);
    check("t0_reload", 16'(cirq[0]), 16'h0001);
    wr_reg(ADDR_T0_DATA_HI, 8'h00);
    wr_reg(ADDR_T0_DATA_LO, 8'h03);
    wr_reg(ADDR_TMR_CTRL, 8'h01);
    repeat (150) @(negedge i_clk);
    rd_exp(ADDR_T0_DATA_LO, 8'h00);
    rd_exp(ADDR_TMR_CTRL, 8'h41);
    $display("test cpu timer done");
    wr_reg(ADDR_TIMER_OUTPUT_LINE_MODE, 8'h01);
    repeat (2) @(negedge i_clk);
    check("timer_output_line_high", 16'(timer_output_line), 16'h0001);
    wr_reg(ADDR_TIMER_OUTPUT_LINE_MODE, 8'h00);
    repeat (2) @(negedge i_clk);
    check("timer_output_line_low", 16'(timer_output_line), 16'h0000);
    wr_reg(ADDR_T1_RLD_LO, 8'h04);
    wr_reg(ADDR_T1_RLD_HI, 8'h00);
    wr_reg(ADDR_T1_DATA_LO, 8'h04);
    wr_reg(ADDR_T1_DATA_HI, 8'h00);
    wr_reg(ADDR_TMR_CTRL, 8'h22);
    wr_reg(ADDR_TIMER_OUTPUT_LINE_MODE, 8'h02);
    run_len(1'b0, n);
    run_len(1'b1, hi);
    run_len(1'b0, n);
    check("timer_output_line_duty", 16'(hi), 16'(n));
    check("timer_output_line_step", 16'(hi % 20), 16'h0000);
    $display("test timer line done");
    wr_reg(ADDR_CHAN0, 8'ha0);
    wr_reg(ADDR_CHAN0, 8'hd5);
    wr_reg(ADDR_CHAN0, 8'h03);
    pulse_pin(0);
    rd_exp(ADDR_CHAN0, 8'h02);
    repeat (2) pulse_pin(0);
    check("zc_held", 16'(zc[0]), 16'h0001);
    check("irq", 16'(pirq), 16'h0001);
    check("vector", 16'(vec), 16'h00a0);
    pulse_pin(0);
    rd_exp(ADDR_CHAN0, 8'h00);
    i_int_ack = 1'b1;
    @(negedge i_clk);
    i_int_ack = 1'b0;
    repeat (2) @(negedge i_clk);
    check("irq_ack", 16'(pirq), 16'h0000);
    $display("test counter mode done");
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(ADDR_CHAN0 + 8'h01, (k == 1) ? 8'h25 : 8'h05);
      wr_reg(ADDR_CHAN0 + 8'h01, (k == 1) ? 8'h01 : 8'h02);
      wait_zc(1, n);
      wait_zc(1, n);
      wait_zc(1, n);
      check("zc_period", 16'(n), (k == 1) ? 16'h0100 : 16'h0020);
      @(negedge i_clk);
      check("zc_pulse", 16'(zc[1]), 16'h0000);
    end
    wr_reg(ADDR_CHAN0 + 8'h02, 8'h1d);
    wr_reg(ADDR_CHAN0 + 8'h02, 8'h01);
    wait_zc(2, n);
    check("trig_wait", 16'(n), 16'h0258);
    pulse_pin(2);
    wait_zc(2, n);
    check("trig_start", 16'(n < 40), 16'h0001);
    $display("test timer mode done");
    wr_reg(ADDR_PERIPH_CMD, 8'h2d);
    check("rst_serial", 16'(rser), 16'h0001);
    @(negedge i_clk);
    check("prio", 16'(prio), 16'h0001);
    check("rst_ser_end", 16'(rser), 16'h0000);
    check("aux", 16'(aux), 16'h0001);
    // both baud channels count the quarter-rate clock in counter mode
    wr_reg(ADDR_PERIPH_CMD, 8'hc0);
    for (int c = 2; c < 4; c++)
    begin
      wr_reg(ADDR_CHAN0 + 8'(c), 8'h45);
      wr_reg(ADDR_CHAN0 + 8'(c), 8'h02);
    end
    repeat (12) @(negedge i_clk);
    check("baud_a", 16'(bauda), 16'h0001);
    check("baud_b", 16'(baudb), 16'h0001);
    wr_reg(ADDR_PERIPH_CMD, 8'h10);
    repeat (2) @(negedge i_clk);
    check("unit_reset", 16'(zc), 16'h0000);
    $display("test command done");
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
